// >>> core/synth_ctrl_pkg.sv
// constants, register map and types for the output synthesis controller
`default_nettype none
package synth_ctrl_pkg;
	// clock and timing
	localparam int CLK_PERIOD_NS  = 40;
	localparam int CAL_SETTLE_NS  = 1000;
	localparam int CAL_SETTLE_CYC =
		(CAL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// serial port frame: rw bit, 7-bit address, 8 data bits
	localparam logic [4:0] SPI_INSTR_BITS = 5'h08;
	localparam logic [4:0] SPI_FRAME_BITS = 5'h10;

	// register addresses
	localparam logic [6:0] ADDR_CP_CURRENT   = 7'h0a;
	localparam logic [6:0] ADDR_VCO_CAL_CTRL = 7'h0e;
	localparam logic [6:0] ADDR_VCO_BAND     = 7'h10;
	localparam logic [6:0] ADDR_FB_INT       = 7'h11;
	localparam logic [6:0] ADDR_FB_FRAC0     = 7'h12;
	localparam logic [6:0] ADDR_FB_FRAC1     = 7'h13;
	localparam logic [6:0] ADDR_FB_FRAC2     = 7'h14;
	localparam logic [6:0] ADDR_FB_MOD0      = 7'h15;
	localparam logic [6:0] ADDR_FB_MOD1      = 7'h16;
	localparam logic [6:0] ADDR_FB_MOD2      = 7'h17;
	localparam logic [6:0] ADDR_POST_DIV0    = 7'h18;
	localparam logic [6:0] ADDR_POST_DIV1    = 7'h19;
	localparam logic [6:0] ADDR_SEC_DIV      = 7'h1a;
	localparam logic [6:0] ADDR_DRV_SEL      = 7'h1b;
	localparam logic [6:0] ADDR_STATUS       = 7'h1c;
	localparam logic [6:0] ADDR_PRI_DRV      = 7'h32;
	localparam logic [6:0] ADDR_SEC_DRV      = 7'h34;

	// field positions
	localparam int CAL_GO_BIT     = 7;
	localparam int CAL_EN_BIT     = 2;
	localparam int BAND_EN_BIT    = 0;
	localparam int DRV_POL_N_BIT  = 7;
	localparam int DRV_POL_P_BIT  = 6;
	localparam int DRV_MODE_LSB   = 3;
	localparam int DRV_STRONG_BIT = 2;
	localparam int DRV_PD_BIT     = 0;

	// reset values
	localparam logic [7:0]  CP_CURRENT_RST = 8'h80;
	localparam logic [7:0]  FB_INT_RST     = 8'h64;
	localparam logic [19:0] FB_FRAC_RST    = 20'h00000;
	localparam logic [19:0] FB_MOD_RST     = 20'h00001;
	localparam logic [5:0]  POST_DIV0_RST  = 6'h04;
	localparam logic [5:0]  POST_DIV1_RST  = 6'h01;
	localparam logic [5:0]  SEC_DIV_RST    = 6'h01;
	localparam logic [7:0]  DRV_CTRL_RST   = 8'h20;
	localparam logic [6:0]  CAL_BAND_START = 7'h40;
	localparam logic [3:0]  FREQ_SEL_19M44 = 4'h0;
	localparam int          XO_W           = 16;

	// driver modes
	localparam logic [2:0] MODE_CMOS_BOTH = 3'h0;
	localparam logic [2:0] MODE_CMOS_POS  = 3'h1;
	localparam logic [2:0] MODE_CMOS_NEG  = 3'h2;
	localparam logic [2:0] MODE_TRI_BOTH  = 3'h3;
	localparam logic [2:0] MODE_LVDS      = 3'h4;
	localparam logic [2:0] MODE_LVPECL    = 3'h5;

	typedef enum logic [1:0]
	{
		FAM_OFF    = 2'h0,
		FAM_CMOS   = 2'h1,
		FAM_LVDS   = 2'h2,
		FAM_LVPECL = 2'h3
	} family_t;

	typedef enum logic [1:0]
	{
		CAL_IDLE   = 2'h0,
		CAL_SEARCH = 2'h1,
		CAL_LEVEL  = 2'h3,
		CAL_DONE   = 2'h2
	} cal_state_t;
endpackage : synth_ctrl_pkg
`default_nettype wire

// >>> core/int_divider.sv
// integer tick divider with a registered clock level and carry tick
`default_nettype none
module int_divider
	import synth_ctrl_pkg::*;
(
	input  wire logic       mclk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       tick_in,
	input  wire logic [5:0] div_in,
	output logic            tick_out,
	output logic            level_out
);
	logic [5:0] cnt;
	logic [5:0] next_cnt;
	logic       next_tick;
	logic       next_level;
	logic [5:0] last;

	always_comb
	begin
		// a zero divide value behaves as divide by one
		last = (div_in == 6'h00) ? 6'h00 : div_in - 6'h01;
		next_cnt = cnt;
		next_tick = 1'b0;
		if (tick_in)
		begin
			if (cnt >= last)
			begin
				next_cnt = 6'h00;
				next_tick = 1'b1;
			end
			else
				next_cnt = cnt + 6'h01;
		end
		next_level = (next_cnt < {1'b0, last[5:1]} + 6'h01);
	end

	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			cnt <= 6'h00;
			tick_out <= 1'b0;
			level_out <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			tick_out <= next_tick;
			level_out <= next_level;
		end
	end
endmodule : int_divider
`default_nettype wire

// >>> core/output_synth_divider_driver_ctrl.sv
// output synthesis control: serial registers, vco calibration, drivers
// Functional notes
// [R1] software-written 8-bit charge pump current replaces the default
// [R2] 128 vco bands, band and level chosen by automatic calibration
// [R3] calibration enable set first, then writing calibrate starts a run
// [R4] band override enable set first, then the 7-bit band is used
// [R5] feedback integer is 8 bits, 0 to 255; software keeps it 64 or more
// [R6] third-order sigma-delta gives integer plus fraction over 20-bit modulus
// [R7] each loop's lock detect drives its own lock status pin
// [R8] post dividers chain: vco, first, second to primary, then secondary
// [R9] driver mode field sits at bits 5 to 3 of each driver register
// [R10] mode codes: cmos variants, tristate, lvds, lvpecl, two undefined
// [R11] cmos modes apply a per-pin polarity from the driver register
// [R12] cmos and lvds modes offer weak or strong drive per driver
// [R13] power-down bit disables a driver whatever family is chosen; with drv_sel clear the code ignores it
// [R14] without serial driver control, family pin picks lvds or lvpecl
// [R15] pin-forced lvds still uses the serially written drive strength
// [R16] both references absent: holdover freezes crystal osc tuning
// [R17] holdover ends when a reference returns, input loop resynchronizes
// [R18] software sets 25 uA charge pump before using 19.44 MHz mode
// [R19] frequency select pins choose normal or 19.44 MHz mode
// [R20] each calibrate write of 1 launches exactly one run; 0 does nothing; the code drops a write of 1 made during a run
`default_nettype none
module output_synth_divider_driver_ctrl
	import synth_ctrl_pkg::*;
(
	input  wire logic              mclk_in,
	input  wire logic              sys_rst_in,
	input  wire logic              spi_sclk_in,
	input  wire logic              spi_cs_n_in,
	input  wire logic              spi_sdio_in,
	output logic                   spi_sdio_out,
	output logic                   spi_sdio_oe_out,
	input  wire logic              ref_a_present_in,
	input  wire logic              ref_b_present_in,
	input  wire logic              input_lock_det_in,
	input  wire logic              output_lock_det_in,
	input  wire logic              output_family_select_pin_in,
	input  wire logic [3:0]        freq_sel_in,
	input  wire logic              vco_cal_cmp_in,
	input  wire logic              vco_tick_in,
	input  wire logic              fb_cycle_in,
	input  wire logic [XO_W-1:0]   xo_tune_in,
	output logic [7:0]             charge_pump_current_out,
	output logic [6:0]             vco_band_out,
	output logic [3:0]             vco_level_out,
	output logic                   vco_cal_busy_out,
	output logic [8:0]             fb_divide_out,
	output logic                   input_lock_out,
	output logic                   output_lock_out,
	output logic                   holdover_out,
	output logic                   input_pll_resync_out,
	output logic [XO_W-1:0]        tunable_crystal_osc_tune_out,
	output logic                   mode_19m44_out,
	output logic [1:0]             pri_pins_out,
	output logic [1:0]             pri_pins_oe_out,
	output logic [1:0]             pri_family_out,
	output logic                   pri_strong_out,
	output logic [1:0]             sec_pins_out,
	output logic [1:0]             sec_pins_oe_out,
	output logic [1:0]             sec_family_out,
	output logic                   sec_strong_out
);
	// pins from outside the clock domain, two flops before use
	logic [12:0] pin_s1;
	logic [12:0] pin_s2;
	logic        sclk_prev;
	logic        sclk, cs_n, sdio, ref_a, ref_b, fam_pin, cal_cmp;
	assign {sclk, cs_n, sdio, ref_a, ref_b} = pin_s2[12:8];
	assign fam_pin = pin_s2[5];
	assign cal_cmp = pin_s2[4];

	// serial port and register state
	logic [4:0]  bit_cnt,   next_bit_cnt;
	logic [14:0] shift_in,  next_shift_in;
	logic [7:0]  rd_shift,  next_rd_shift;
	logic        sdio_oe,   next_sdio_oe;
	logic [7:0]  cp_cur,    next_cp_cur;
	logic [7:0]  cal_ctrl,  next_cal_ctrl;
	logic [6:0]  band_ovr,  next_band_ovr;
	logic [7:0]  fb_int,    next_fb_int;
	logic [19:0] fb_frac,   next_fb_frac;
	logic [19:0] fb_mod,    next_fb_mod;
	logic [5:0]  pdiv0,     next_pdiv0;
	logic [5:0]  pdiv1,     next_pdiv1;
	logic [5:0]  sdiv,      next_sdiv;
	logic        drv_sel,   next_drv_sel;
	logic [7:0]  pri_drv,   next_pri_drv;
	logic [7:0]  sec_drv,   next_sec_drv;
	logic        cal_go;
	logic        wr_en;
	logic [6:0]  wr_addr;
	logic [7:0]  wr_data;
	logic [7:0]  rd_val;
	logic [6:0]  rd_addr;

	always_comb
	begin
		next_bit_cnt = bit_cnt;
		next_shift_in = shift_in;
		next_rd_shift = rd_shift;
		next_sdio_oe = sdio_oe;
		wr_en = 1'b0;
		wr_addr = shift_in[13:7];
		wr_data = {shift_in[6:0], sdio};
		rd_addr = {shift_in[5:0], sdio};
		if (cs_n)
		begin
			next_bit_cnt = 5'h00;
			next_sdio_oe = 1'b0;
		end
		else if (sclk && !sclk_prev && bit_cnt != SPI_FRAME_BITS)
		begin
			next_shift_in = {shift_in[13:0], sdio};
			next_bit_cnt = bit_cnt + 5'h01;
			if (bit_cnt == SPI_INSTR_BITS - 5'h01 && shift_in[6])
			begin
				next_rd_shift = rd_val;
				next_sdio_oe = 1'b1;
			end
			wr_en = (bit_cnt == SPI_FRAME_BITS - 5'h01) && !shift_in[14];
		end
		else if (!sclk && sclk_prev && bit_cnt > SPI_INSTR_BITS)
			next_rd_shift = {rd_shift[6:0], 1'b0};
	end

	always_comb
	begin
		case (rd_addr)
			ADDR_CP_CURRENT:   rd_val = cp_cur;
			ADDR_VCO_CAL_CTRL: rd_val = {vco_cal_busy_out, cal_ctrl[6:0]};
			ADDR_VCO_BAND:     rd_val = {band_ovr, 1'b0};
			ADDR_FB_INT:       rd_val = fb_int;
			ADDR_FB_FRAC0:     rd_val = fb_frac[7:0];
			ADDR_FB_FRAC1:     rd_val = fb_frac[15:8];
			ADDR_FB_FRAC2:     rd_val = {4'h0, fb_frac[19:16]};
			ADDR_FB_MOD0:      rd_val = fb_mod[7:0];
			ADDR_FB_MOD1:      rd_val = fb_mod[15:8];
			ADDR_FB_MOD2:      rd_val = {4'h0, fb_mod[19:16]};
			ADDR_POST_DIV0:    rd_val = {2'h0, pdiv0};
			ADDR_POST_DIV1:    rd_val = {2'h0, pdiv1};
			ADDR_SEC_DIV:      rd_val = {2'h0, sdiv};
			ADDR_DRV_SEL:      rd_val = {7'h00, drv_sel};
			ADDR_STATUS:       rd_val = {3'h0, mode_19m44_out,
				holdover_out, vco_cal_busy_out, output_lock_out,
				input_lock_out};
			ADDR_PRI_DRV:      rd_val = pri_drv;
			ADDR_SEC_DRV:      rd_val = sec_drv;
			default:           rd_val = 8'h00;
		endcase
	end

	always_comb
	begin
		next_cp_cur = cp_cur;
		next_cal_ctrl = cal_ctrl;
		next_band_ovr = band_ovr;
		next_fb_int = fb_int;
		next_fb_frac = fb_frac;
		next_fb_mod = fb_mod;
		next_pdiv0 = pdiv0;
		next_pdiv1 = pdiv1;
		next_sdiv = sdiv;
		next_drv_sel = drv_sel;
		next_pri_drv = pri_drv;
		next_sec_drv = sec_drv;
		cal_go = 1'b0;
		if (wr_en)
		begin
			case (wr_addr)
				ADDR_CP_CURRENT:   next_cp_cur = wr_data;  // [R1]
				ADDR_VCO_CAL_CTRL:
				begin
					// calibrate is a trigger, never stored
					next_cal_ctrl = {1'b0, wr_data[6:0]};
					cal_go = wr_data[CAL_GO_BIT]
						&& cal_ctrl[CAL_EN_BIT];  // [R3] [R20]
				end
				ADDR_VCO_BAND:     next_band_ovr = wr_data[7:1];  // [R4]
				ADDR_FB_INT:       next_fb_int = wr_data;  // [R5]
				ADDR_FB_FRAC0:     next_fb_frac[7:0] = wr_data;
				ADDR_FB_FRAC1:     next_fb_frac[15:8] = wr_data;
				ADDR_FB_FRAC2:     next_fb_frac[19:16] = wr_data[3:0];
				ADDR_FB_MOD0:      next_fb_mod[7:0] = wr_data;
				ADDR_FB_MOD1:      next_fb_mod[15:8] = wr_data;
				ADDR_FB_MOD2:      next_fb_mod[19:16] = wr_data[3:0];
				ADDR_POST_DIV0:    next_pdiv0 = wr_data[5:0];
				ADDR_POST_DIV1:    next_pdiv1 = wr_data[5:0];
				ADDR_SEC_DIV:      next_sdiv = wr_data[5:0];
				ADDR_DRV_SEL:      next_drv_sel = wr_data[0];
				ADDR_PRI_DRV:      next_pri_drv = wr_data;
				ADDR_SEC_DRV:      next_sec_drv = wr_data;
				default:           next_cp_cur = cp_cur;
			endcase
		end
	end

	// vco calibration: binary band search, then amplitude steps
	cal_state_t cal_st, next_cal_st;
	logic [6:0] cal_band, next_cal_band;
	logic [2:0] cal_bit,  next_cal_bit;
	logic [4:0] settle,   next_settle;
	logic [3:0] level,    next_level;
	logic       cal_pend, next_cal_pend;

	always_comb
	begin
		next_cal_st = cal_st;
		next_cal_band = cal_band;
		next_cal_bit = cal_bit;
		next_settle = (settle == 5'h00) ? 5'h00 : settle - 5'h01;
		next_level = level;
		// a trigger during a run is dropped, so one write gives one run
		next_cal_pend = cal_pend;
		case (cal_st)
			CAL_IDLE:
				if (cal_pend || cal_go)  // [R2] [R3] [R20]
				begin
					next_cal_pend = 1'b0;
					next_cal_st = CAL_SEARCH;
					next_cal_band = CAL_BAND_START;
					next_cal_bit = 3'h6;
					next_level = 4'h0;
					next_settle = 5'(CAL_SETTLE_CYC);
				end
			CAL_SEARCH:
				if (settle == 5'h00)
				begin
					next_settle = 5'(CAL_SETTLE_CYC);
					// comparator high means vco still too slow
					if (!cal_cmp)
						next_cal_band = cal_band & ~(7'h01 << cal_bit);
					if (cal_bit == 3'h0)
						next_cal_st = CAL_LEVEL;
					else
					begin
						next_cal_bit = cal_bit - 3'h1;
						next_cal_band = next_cal_band
							| (7'h01 << (cal_bit - 3'h1));
					end
				end
			CAL_LEVEL:
				if (settle == 5'h00)
				begin
					next_settle = 5'(CAL_SETTLE_CYC);
					if (cal_cmp && level != 4'hf)
						next_level = level + 4'h1;
					else
						next_cal_st = CAL_DONE;
				end
			CAL_DONE:
				next_cal_st = CAL_IDLE;
			default:
				next_cal_st = CAL_IDLE;
		endcase
	end

	// third-order mash sigma-delta for the feedback divider
	logic        fb_prev;
	logic [19:0] acc1, acc2, acc3;
	logic [19:0] next_acc1, next_acc2, next_acc3;
	logic        c2d, c3d, c3dd;
	logic        c1, c2, c3;
	logic [8:0]  next_fb_div;
	logic [9:0]  fb_sum;

	function automatic logic [20:0] mod_add(input logic [19:0] a,
		input logic [19:0] b, input logic [19:0] m);
		logic [20:0] s;
		s = {1'b0, a} + {1'b0, b};
		// zero modulus disables the fraction instead of dividing by zero
		if (m != 20'h00000 && s >= {1'b0, m})
			mod_add = {1'b1, 20'(s - {1'b0, m})};
		else
			mod_add = {1'b0, s[19:0]};
	endfunction : mod_add

	always_comb
	begin
		{c1, next_acc1} = mod_add(acc1, fb_frac, fb_mod);
		{c2, next_acc2} = mod_add(acc2, next_acc1, fb_mod);
		{c3, next_acc3} = mod_add(acc3, next_acc2, fb_mod);
		fb_sum = {2'h0, fb_int} + {9'h000, c1} + {9'h000, c2}
			- {9'h000, c2d} + {9'h000, c3} - {8'h00, c3d, 1'b0}
			+ {9'h000, c3dd};  // [R6]
		next_fb_div = fb_sum[8:0];
	end

	// holdover and driver config
	logic [XO_W-1:0]   xo_hold;
	logic              hold_prev;
	logic              hold_now;
	logic [7:0]        pri_eff, sec_eff;
	logic [6:0]        pri_pack, sec_pack;
	logic              d0_tick, d1_tick, d1_level, d2_level;

	assign hold_now = !ref_a && !ref_b;  // [R16]

	function automatic logic [7:0] eff_cfg(input logic [7:0] r,
		input logic sel, input logic pin);
		// pin default keeps only the strength bit of the register
		if (sel)
			eff_cfg = r;
		else
			eff_cfg = {2'h0, pin ? MODE_LVPECL : MODE_LVDS,
				r[DRV_STRONG_BIT], 2'h0};  // [R14] [R15]
	endfunction : eff_cfg

	function automatic logic [6:0] drive(input logic [7:0] c,
		input logic lvl);
		logic [2:0] md;
		logic       p, n;
		md = c[DRV_MODE_LSB +: 3];  // [R9]
		p = lvl ^ c[DRV_POL_P_BIT];  // [R11]
		n = lvl ^ c[DRV_POL_N_BIT];
		case (md)  // [R10]
			MODE_CMOS_BOTH: drive = {FAM_CMOS, c[2], 2'b11, p, n};
			MODE_CMOS_POS:  drive = {FAM_CMOS, c[2], 2'b10, p, 1'b0};
			MODE_CMOS_NEG:  drive = {FAM_CMOS, c[2], 2'b01, 1'b0, n};
			MODE_TRI_BOTH:  drive = {FAM_CMOS, 1'b0, 4'h0};
			MODE_LVDS:      drive = {FAM_LVDS, c[2], 2'b11, lvl, !lvl};
			MODE_LVPECL:    drive = {FAM_LVPECL, 1'b0, 2'b11, lvl, !lvl};
			default:        drive = 7'h00;
		endcase
		if (c[DRV_PD_BIT])
			drive = 7'h00;  // [R13]
	endfunction : drive

	assign pri_eff = eff_cfg(pri_drv, drv_sel, fam_pin);
	assign sec_eff = eff_cfg(sec_drv, drv_sel, fam_pin);
	assign pri_pack = drive(pri_eff, d1_level);  // [R12]
	assign sec_pack = drive(sec_eff, d2_level);

	int_divider u_first_post_divider (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.tick_in    (vco_tick_in),
		.div_in     (pdiv0),
		.tick_out   (d0_tick),
		.level_out  ()
	);  // [R8]
	int_divider u_second_post_divider (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.tick_in    (d0_tick),
		.div_in     (pdiv1),
		.tick_out   (d1_tick),
		.level_out  (d1_level)
	);
	int_divider u_secondary_output_divider (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.tick_in    (d1_tick),
		.div_in     (sdiv),
		.tick_out   (),
		.level_out  (d2_level)
	);

	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			pin_s1 <= 13'h0b00;
			pin_s2 <= 13'h0b00;
			sclk_prev <= 1'b0;
			bit_cnt <= 5'h00;
			shift_in <= 15'h0000;
			rd_shift <= 8'h00;
			sdio_oe <= 1'b0;
			cp_cur <= CP_CURRENT_RST;
			cal_ctrl <= 8'h00;
			band_ovr <= 7'h00;
			fb_int <= FB_INT_RST;
			fb_frac <= FB_FRAC_RST;
			fb_mod <= FB_MOD_RST;
			pdiv0 <= POST_DIV0_RST;
			pdiv1 <= POST_DIV1_RST;
			sdiv <= SEC_DIV_RST;
			drv_sel <= 1'b0;
			pri_drv <= DRV_CTRL_RST;
			sec_drv <= DRV_CTRL_RST;
			cal_st <= CAL_IDLE;
			cal_band <= CAL_BAND_START;
			cal_bit <= 3'h0;
			settle <= 5'h00;
			level <= 4'h0;
			cal_pend <= 1'b1;
			fb_prev <= 1'b0;
			acc1 <= 20'h00000;
			acc2 <= 20'h00000;
			acc3 <= 20'h00000;
			{c2d, c3d, c3dd} <= 3'h0;
			fb_divide_out <= 9'h000;
			xo_hold <= '0;
			hold_prev <= 1'b0;
			tunable_crystal_osc_tune_out <= '0;
			input_pll_resync_out <= 1'b0;
			{pri_family_out, pri_strong_out} <= 3'h0;
			{pri_pins_oe_out, pri_pins_out} <= 4'h0;
			{sec_family_out, sec_strong_out} <= 3'h0;
			{sec_pins_oe_out, sec_pins_out} <= 4'h0;
		end
		else
		begin
			pin_s1 <= {spi_sclk_in, spi_cs_n_in, spi_sdio_in,
				ref_a_present_in, ref_b_present_in, input_lock_det_in,
				output_lock_det_in, output_family_select_pin_in,
				vco_cal_cmp_in, freq_sel_in};
			pin_s2 <= pin_s1;
			sclk_prev <= sclk;
			bit_cnt <= next_bit_cnt;
			shift_in <= next_shift_in;
			rd_shift <= next_rd_shift;
			sdio_oe <= next_sdio_oe;
			cp_cur <= next_cp_cur;
			cal_ctrl <= next_cal_ctrl;
			band_ovr <= next_band_ovr;
			fb_int <= next_fb_int;
			fb_frac <= next_fb_frac;
			fb_mod <= next_fb_mod;
			pdiv0 <= next_pdiv0;
			pdiv1 <= next_pdiv1;
			sdiv <= next_sdiv;
			drv_sel <= next_drv_sel;
			pri_drv <= next_pri_drv;
			sec_drv <= next_sec_drv;
			cal_st <= next_cal_st;
			cal_band <= next_cal_band;
			cal_bit <= next_cal_bit;
			settle <= next_settle;
			level <= next_level;
			cal_pend <= next_cal_pend;
			fb_prev <= fb_cycle_in;
			if (fb_cycle_in && !fb_prev)
			begin
				acc1 <= next_acc1;
				acc2 <= next_acc2;
				acc3 <= next_acc3;
				{c2d, c3d, c3dd} <= {c2, c3, c3d};
				fb_divide_out <= next_fb_div;
			end
			hold_prev <= hold_now;
			// last tuning word before holdover is kept frozen
			if (!hold_now)
				xo_hold <= xo_tune_in;
			tunable_crystal_osc_tune_out <=
				hold_now ? xo_hold : xo_tune_in;  // [R16]
			input_pll_resync_out <= hold_prev && !hold_now;  // [R17]
			{pri_family_out, pri_strong_out} <= pri_pack[6:4];
			{pri_pins_oe_out, pri_pins_out} <= pri_pack[3:0];
			{sec_family_out, sec_strong_out} <= sec_pack[6:4];
			{sec_pins_oe_out, sec_pins_out} <= sec_pack[3:0];
		end
	end

	assign spi_sdio_out = rd_shift[7];
	assign spi_sdio_oe_out = sdio_oe;
	assign charge_pump_current_out = cp_cur;  // [R1]
	assign vco_band_out = cal_ctrl[BAND_EN_BIT] ? band_ovr : cal_band;  // [R4]
	assign vco_level_out = level;
	assign vco_cal_busy_out = (cal_st != CAL_IDLE);
	assign input_lock_out = pin_s2[7];  // [R7]
	assign output_lock_out = pin_s2[6];  // [R7]
	assign holdover_out = hold_now;
	assign mode_19m44_out = (pin_s2[3:0] == FREQ_SEL_19M44);  // [R19]

	cal_one_run_a: assert property (@(posedge mclk_in) disable iff  // [R20]
		(sys_rst_in) cal_go && cal_st != CAL_IDLE |=> !cal_pend)
		else $error("calibrate during a run was queued");
	cal_start_a: assert property (@(posedge mclk_in) disable iff  // [R3]
		(sys_rst_in) cal_go && cal_st == CAL_IDLE |=> cal_st == CAL_SEARCH)
		else $error("calibrate trigger did not start a run");
	band_ovr_a: assert property (@(posedge mclk_in) disable iff  // [R4]
		(sys_rst_in) cal_ctrl[0] |-> vco_band_out == band_ovr)
		else $error("band override not applied");
	pd_off_a: assert property (@(posedge mclk_in) disable iff  // [R13]
		(sys_rst_in) drv_sel && sec_drv[0] |=> sec_pins_oe_out == 2'h0)
		else $error("powered-down driver still enabled");
	pin_family_a: assert property (@(posedge mclk_in) disable iff  // [R14]
		(sys_rst_in) !drv_sel && !sec_drv[0] |=> sec_family_out ==
		($past(fam_pin) ? FAM_LVPECL : FAM_LVDS))
		else $error("pin-selected family wrong");
	lvds_strength_a: assert property (@(posedge mclk_in) disable iff  // [R15]
		(sys_rst_in) !drv_sel && !fam_pin |=> pri_strong_out ==
		$past(pri_drv[2]))
		else $error("pin lvds ignores drive strength");
	hold_freeze_a: assert property (@(posedge mclk_in) disable iff  // [R16]
		(sys_rst_in) hold_now && $past(hold_now) |=>
		$stable(tunable_crystal_osc_tune_out))
		else $error("tuning moved during holdover");
	resync_a: assert property (@(posedge mclk_in) disable iff  // [R17]
		(sys_rst_in) $fell(hold_now) |=> input_pll_resync_out ##1
		!input_pll_resync_out)
		else $error("resync pulse missing on holdover exit");
	cal_bound_a: assert property (@(posedge mclk_in) disable iff  // [R2]
		(sys_rst_in) $rose(vco_cal_busy_out) |-> ##[1:700]
		!vco_cal_busy_out)
		else $error("calibration did not finish");
	cp_write_a: assert property (@(posedge mclk_in) disable iff  // [R1]
		(sys_rst_in) wr_en && wr_addr == ADDR_CP_CURRENT |=>
		charge_pump_current_out == $past(wr_data))
		else $error("charge pump write lost");
	cal_run_c: cover property (@(posedge mclk_in) cal_st == CAL_DONE);
	hold_exit_c: cover property (@(posedge mclk_in) input_pll_resync_out);
	spi_read_c: cover property (@(posedge mclk_in) $rose(sdio_oe));
	lvpecl_c: cover property (@(posedge mclk_in)
		pri_family_out == FAM_LVPECL);
endmodule : output_synth_divider_driver_ctrl
`default_nettype wire

// >>> tb/ref_side_model.sv
// far side model: references, lock detectors, crystal word, vco strobes
`default_nettype none
module ref_side_model
	import synth_ctrl_pkg::*;
(
	input  wire logic         mclk_in,
	input  wire logic         refs_on_in,
	output logic              ref_a_out,
	output logic              ref_b_out,
	output logic              in_lock_out,
	output logic              out_lock_out,
	output logic              tick_out,
	output logic              fb_out,
	output logic              cmp_out,
	output logic [XO_W-1:0]   tune_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [XO_W-1:0] cnt = '0;
	always @(posedge mclk_in)
	begin
		cnt <= cnt + 16'h0001;
	end
	// both references come and go together so holdover can be forced
	assign ref_a_out = refs_on_in;
	assign ref_b_out = refs_on_in;
	assign in_lock_out = refs_on_in;
	assign out_lock_out = refs_on_in;
	assign tick_out = cnt[0];
	assign fb_out = cnt[2];
	assign cmp_out = cnt[5];
	// word moves every cycle, so a missed freeze cannot look frozen
	assign tune_out = cnt;
endmodule : ref_side_model
`default_nettype wire

// >>> tb/output_synth_divider_driver_ctrl_tb.sv
// self-checking bench for the output synthesis controller
`default_nettype none
module output_synth_divider_driver_ctrl_tb import synth_ctrl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_in = 0, sys_rst_in = 1, spi_sclk_in = 0, spi_cs_n_in = 1;
	logic host_sdio = 0, output_family_select_pin_in = 0, refs_on = 1;
	logic [3:0] freq_sel_in = 4'h5;
	integer seed = 32'h79ac, miscompares = 0, tests_run = 0, i;
	logic [7:0] rd, v;
	logic [15:0] hold;
	wire spi_sdio_out, spi_sdio_oe_out, ref_a_present_in, ref_b_present_in;
	wire input_lock_det_in, output_lock_det_in, vco_cal_cmp_in, vco_tick_in;
	wire fb_cycle_in, vco_cal_busy_out, input_lock_out, output_lock_out;
	wire holdover_out, input_pll_resync_out, mode_19m44_out;
	wire pri_strong_out, sec_strong_out;
	wire [XO_W-1:0] xo_tune_in, tunable_crystal_osc_tune_out;
	wire [7:0] charge_pump_current_out;
	wire [6:0] vco_band_out;
	wire [3:0] vco_level_out;
	wire [8:0] fb_divide_out;
	wire [1:0] pri_pins_out, pri_pins_oe_out, pri_family_out;
	wire [1:0] sec_pins_out, sec_pins_oe_out, sec_family_out;
	wire spi_sdio_in = spi_sdio_oe_out ? spi_sdio_out : host_sdio;
	ref_side_model i_far (.mclk_in, .refs_on_in(refs_on),
		.ref_a_out(ref_a_present_in), .ref_b_out(ref_b_present_in),
		.in_lock_out(input_lock_det_in), .out_lock_out(output_lock_det_in),
		.tick_out(vco_tick_in), .fb_out(fb_cycle_in),
		.cmp_out(vco_cal_cmp_in), .tune_out(xo_tune_in));
	output_synth_divider_driver_ctrl i_dut (.mclk_in, .sys_rst_in,
		.spi_sclk_in, .spi_cs_n_in, .spi_sdio_in, .spi_sdio_out,
		.spi_sdio_oe_out, .ref_a_present_in, .ref_b_present_in,
		.input_lock_det_in, .output_lock_det_in, .output_family_select_pin_in,
		.freq_sel_in, .vco_cal_cmp_in, .vco_tick_in, .fb_cycle_in,
		.xo_tune_in, .charge_pump_current_out, .vco_band_out,
		.vco_level_out, .vco_cal_busy_out, .fb_divide_out, .input_lock_out,
		.output_lock_out, .holdover_out, .input_pll_resync_out,
		.tunable_crystal_osc_tune_out, .mode_19m44_out, .pri_pins_out,
		.pri_pins_oe_out, .pri_family_out, .pri_strong_out, .sec_pins_out,
		.sec_pins_oe_out, .sec_family_out, .sec_strong_out);
	task automatic tally_and_finish();
		$display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	task automatic step(input int n);
		repeat (n) @(posedge mclk_in);
		#2;
	endtask : step
	task automatic check(input string nm, input logic [19:0] seen, exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// half periods of 4 cover the 3-cycle pin sync
	task automatic spi(input logic rw, input logic [6:0] a, input logic [7:0] d);
		logic [15:0] f;
		f = {rw, a, d};
		spi_cs_n_in = 0;
		for (int b = 15; b >= 0; b--)
		begin
			host_sdio = f[b];
			step(4);
			spi_sclk_in = 1;
			rd = {rd[6:0], spi_sdio_in};
			step(4);
			spi_sclk_in = 0;
		end
		step(4);
		spi_cs_n_in = 1;
		step(6);
	endtask : spi
	task automatic await_idle();
		for (i = 0; i < 3000 && vco_cal_busy_out !== 1'b0; i++) step(1);
		if (i >= 3000)
		begin
			miscompares++;
			tally_and_finish();
		end
	endtask : await_idle
	function automatic logic [1:0] drv_exp(input logic [2:0] m);
		logic [1:0] t [8] = '{2'h3, 2'h2, 2'h1, 2'h0, FAM_LVDS, FAM_LVPECL,
			FAM_OFF, FAM_OFF};
		return t[m];
	endfunction : drv_exp
	initial
	begin
		forever #20 mclk_in = ~mclk_in;
	end
	initial
	begin
		step(3);
		sys_rst_in = 0;
		check("cp rst", charge_pump_current_out, CP_CURRENT_RST);
		step(4);
		check("auto cal", vco_cal_busy_out, 1'b1);
		v = $random(seed);
		spi(0, ADDR_CP_CURRENT, v);
		check("cp", charge_pump_current_out, v);
		spi(1, ADDR_CP_CURRENT, 8'h00);
		check("cp rd", rd, v);
		spi(1, 7'h7f, 8'h00);
		check("unmapped", rd, 8'h00);
		await_idle();
		spi(0, ADDR_VCO_CAL_CTRL, 8'h84);
		check("cal no en", vco_cal_busy_out, 1'b0);
		spi(0, ADDR_VCO_CAL_CTRL, 8'h84);
		check("cal go", vco_cal_busy_out, 1'b1);
		spi(0, ADDR_VCO_CAL_CTRL, 8'h84);
		await_idle();
		spi(0, ADDR_VCO_CAL_CTRL, 8'h04);
		check("cal zero", vco_cal_busy_out, 1'b0);
		v = $random(seed);
		spi(0, ADDR_VCO_CAL_CTRL, 8'h05);
		spi(0, ADDR_VCO_BAND, v);
		check("band", vco_band_out, v[7:1]);
		check("fb rst", fb_divide_out, FB_INT_RST);
		spi(0, ADDR_FB_INT, 8'hff);
		check("fb max", fb_divide_out, 9'h0ff);
		spi(0, ADDR_DRV_SEL, 8'h01);
		for (i = 0; i < 8; i++)
		begin
			spi(0, ADDR_PRI_DRV, {2'h0, i[2:0], 3'h0});
			v[1:0] = (i < 4) ? pri_pins_oe_out : pri_family_out;
			check("pri mode", v[1:0], drv_exp(i[2:0]));
		end
		spi(0, ADDR_PRI_DRV, 8'h80);
		check("pol n", pri_pins_out[1] ^ pri_pins_out[0], 1'b1);
		spi(0, ADDR_SEC_DRV, 8'h21);
		check("pd", sec_family_out, FAM_OFF);
		spi(0, ADDR_SEC_DRV, 8'h24);
		check("strong", sec_strong_out, 1'b1);
		spi(0, ADDR_DRV_SEL, 8'h00);
		output_family_select_pin_in = 1;
		step(6);
		check("pin pecl", pri_family_out, FAM_LVPECL);
		output_family_select_pin_in = 0;
		step(6);
		check("pin lvds", sec_family_out, FAM_LVDS);
		check("pin drive", sec_strong_out, 1'b1);
		refs_on = 0;
		step(8);
		check("hold", holdover_out, 1'b1);
		check("unlock", input_lock_out, 1'b0);
		hold = tunable_crystal_osc_tune_out;
		step(9);
		check("frozen", tunable_crystal_osc_tune_out, hold);
		refs_on = 1;
		for (i = 0; i < 50 && input_pll_resync_out !== 1'b1; i++) step(1);
		check("resync", i < 50, 1'b1);
		check("lock", output_lock_out, 1'b1);
		spi(0, ADDR_CP_CURRENT, 8'h19);
		freq_sel_in = FREQ_SEL_19M44;
		step(5);
		check("m19", mode_19m44_out, 1'b1);
		tally_and_finish();
	end
endmodule : output_synth_divider_driver_ctrl_tb
`default_nettype wire
